//--- hw/uia_map.svh
// Purpose: constants for the usb interrupt autovector block
// Assumes: included by bare name
// Notes: offsets are processor-side register addresses
`ifndef UIA_MAP_SVH
`define UIA_MAP_SVH
`define UIA_OFF_OUT_IRQ 16'h7faa
`define UIA_OFF_USB_IRQ 16'h7fab
`define UIA_OFF_IN_ENA 16'h7fac
`define UIA_OFF_OUT_ENA 16'h7fad
`define UIA_OFF_IN_IRQ 16'h7fa9
`define UIA_OFF_USB_ENA 16'h7fae
`define UIA_OFF_BAV 16'h7faf
`define UIA_OFF_TW_CS 16'h7fa5
`define UIA_OFF_TW_DAT 16'h7fa6
`define UIA_OFF_EXT_ENA 16'h7fb0
`define UIA_OFF_EXT_FLAG 16'h7fb1
`define UIA_AV_BIT 0
`define UIA_TW_DONE_BIT 0
`define UIA_TW_STOP_BIT 6
`define UIA_TW_ENA_BIT 1
`define UIA_TW_FLAG_BIT 5
`define UIA_JMP_ADDR 16'h0043
`define UIA_AV_BYTE_ADDR 16'h0045
`define UIA_JMP_OPCODE 8'h02
`define UIA_AV_EP_BASE 8'h18
`define UIA_RST_BYTE 8'h00
`define UIA_STOP_CYCLES 8'h0a
`define UIA_DISPATCH_MAX 8
`endif

//--- hw/uia_pkg.sv
// Purpose: shared types for the usb interrupt autovector block
// Assumes: nothing
// Notes: types only
package uia_pkg;
   typedef logic [7:0] uia_byte_t;
   typedef logic [15:0] uia_addr_t;
   typedef enum logic [1:0]
   {
      UIA_TW_IDLE = 2'b00,
      UIA_TW_XFER = 2'b01,
      UIA_TW_STOP = 2'b10
   } uia_tw_state_t;
endpackage : uia_pkg

//--- hw/uia_if.sv
// Purpose: joins the interrupt device and the processor side
// Assumes: one clock
// Notes: rd_data valid one cycle after rd_strobe
`timescale 1ns/1ps
interface uia_if;
   logic [15:0] addr;
   logic [7:0] wr_data;
   logic wr_strobe;
   logic rd_strobe;
   logic [7:0] rd_data;
   logic fetch;
   logic [15:0] fetch_addr;
   logic [7:0] fetch_data;
   logic fetch_subst;
   logic usb_irq;
   logic tw_irq;
   modport device
   (
      input addr, wr_data, wr_strobe, rd_strobe, fetch, fetch_addr,
      output rd_data, fetch_data, fetch_subst, usb_irq, tw_irq
   );
   modport cpu
   (
      output addr, wr_data, wr_strobe, rd_strobe, fetch, fetch_addr,
      input rd_data, fetch_data, fetch_subst, usb_irq, tw_irq
   );
endinterface : uia_if

//--- hw/uia_device.sv
// Purpose: usb interrupt requests, autovector and two-wire interrupt
// Assumes: processor side takes fetch_data only while fetch_subst is high
// Notes:
`timescale 1ns/1ps
`include "uia_map.svh"
module uia_device
(
   input wire logic clock,
   input wire logic sys_rst,
   uia_if.device bus,
   input wire logic [7:0] in_busy,
   input wire logic [7:0] out_busy,
   input wire logic [4:0] core_evt,
   input wire logic tw_byte_done,
   input wire logic tw_stop_sent,
   output logic tw_stop_req
);
   // ----------------------------------------
   // request and enable state
   // ----------------------------------------
   logic [7:0] in_busy_reg, out_busy_reg;
   logic [7:0] in_irq_reg, out_ep_request_bits_reg, in_ena_reg, out_ena_reg;
   logic [4:0] usb_irq_reg, usb_ena_reg;
   logic autovector_enable_reg;
   logic [7:0] tw_cs_reg, tw_dat_reg, ext_ena_reg, ext_flag_reg;
   logic [7:0] rd_data_reg;
   uia_pkg::uia_tw_state_t tw_state_reg;
   wire wr = bus.wr_strobe;
   wire rd = bus.rd_strobe;
   wire [7:0] wd = bus.wr_data;
   wire sel_tw = (bus.addr == `UIA_OFF_TW_CS) || (bus.addr == `UIA_OFF_TW_DAT);
   wire stopping = (tw_state_reg == uia_pkg::UIA_TW_STOP);
   wire tw_acc = sel_tw && (wr || rd) && !stopping;
   // busy falling edge marks buffer handed to the processor
   wire [7:0] in_fall = in_busy_reg & ~in_busy;
   wire [7:0] out_fall = out_busy_reg & ~out_busy;
   wire [7:0] clr_in = (wr && bus.addr == `UIA_OFF_IN_IRQ) ? wd : 8'h00;
   wire [7:0] clr_out = (wr && bus.addr == `UIA_OFF_OUT_IRQ) ? wd : 8'h00;
   wire [4:0] clr_usb = (wr && bus.addr == `UIA_OFF_USB_IRQ) ? wd[4:0] : 5'h00;
   wire [4:0] usb_pend = usb_irq_reg & usb_ena_reg;
   wire [7:0] in_pend = in_irq_reg & in_ena_reg;
   wire [7:0] out_pend = out_ep_request_bits_reg & out_ena_reg;
   wire [20:0] pend = {out_pend[7], in_pend[7], out_pend[6], in_pend[6],
      out_pend[5], in_pend[5], out_pend[4], in_pend[4], out_pend[3], in_pend[3],
      out_pend[2], in_pend[2], out_pend[1], in_pend[1], out_pend[0], in_pend[0],
      usb_pend};

   // slot index to code; code 14 reserved, endpoints start at 18
   function automatic logic [7:0] uia_code(input logic [4:0] slot);
      logic [4:0] s;
      s = (slot < 5'd5) ? slot : slot + 5'd1;
      uia_code = {1'b0, s, 2'b00};
   endfunction : uia_code

   // lowest pending slot gives the lowest code
   function automatic logic [4:0] uia_first(input logic [20:0] p);
      logic [4:0] idx;
      idx = 5'd0;
      for (int i = 20; i >= 0; i--)
      begin
         if (p[i])
         begin
            idx = 5'(i);
         end
      end
      uia_first = idx;
   endfunction : uia_first

   wire [7:0] autovector_byte = uia_code(uia_first(pend));
   wire subst = bus.fetch && autovector_enable_reg && (bus.fetch_addr == `UIA_AV_BYTE_ADDR);
   // outside the substitution cycle the byte reads as zero
   assign bus.fetch_data = subst ? autovector_byte : `UIA_RST_BYTE;
   assign bus.fetch_subst = subst;
   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign bus.usb_irq = |pend;
   assign bus.tw_irq = ext_flag_reg[`UIA_TW_FLAG_BIT] & ext_ena_reg[`UIA_TW_ENA_BIT];
   assign bus.rd_data = rd_data_reg;
   assign tw_stop_req = tw_cs_reg[`UIA_TW_STOP_BIT];
   wire done_rise = tw_byte_done && !tw_cs_reg[`UIA_TW_DONE_BIT];
   wire tw_dat_wr = tw_acc && wr && (bus.addr == `UIA_OFF_TW_DAT);
   wire tw_cs_wr = tw_acc && wr && (bus.addr == `UIA_OFF_TW_CS);
   wire flag_zero_wr = wr && (bus.addr == `UIA_OFF_EXT_FLAG) && !wd[`UIA_TW_FLAG_BIT];
   wire rd_ok = rd && !(sel_tw && stopping);
   wire [7:0] rd_mux =
      (bus.addr == `UIA_OFF_IN_IRQ) ? in_irq_reg :
      (bus.addr == `UIA_OFF_OUT_IRQ) ? out_ep_request_bits_reg :
      (bus.addr == `UIA_OFF_USB_IRQ) ? {3'h0, usb_irq_reg} :
      (bus.addr == `UIA_OFF_IN_ENA) ? in_ena_reg :
      (bus.addr == `UIA_OFF_OUT_ENA) ? out_ena_reg :
      (bus.addr == `UIA_OFF_USB_ENA) ? {3'h0, usb_ena_reg} :
      (bus.addr == `UIA_OFF_BAV) ? {7'h00, autovector_enable_reg} :
      (bus.addr == `UIA_OFF_TW_CS) ? tw_cs_reg :
      (bus.addr == `UIA_OFF_TW_DAT) ? tw_dat_reg :
      (bus.addr == `UIA_OFF_EXT_ENA) ? ext_ena_reg :
      (bus.addr == `UIA_OFF_EXT_FLAG) ? ext_flag_reg : 8'h00;
   // ----------------------------------------
   // endpoint and usb requests
   // ----------------------------------------
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         in_busy_reg <= 8'h00;
         out_busy_reg <= 8'h00;
         in_irq_reg <= 8'h00;
         out_ep_request_bits_reg <= 8'h00;
         usb_irq_reg <= 5'h00;
      end
      else
      begin
         in_busy_reg <= in_busy;
         out_busy_reg <= out_busy;
         // set wins over write-one clear
         in_irq_reg <= (in_irq_reg & ~clr_in) | in_fall;
         out_ep_request_bits_reg <= (out_ep_request_bits_reg & ~clr_out) | out_fall;
         usb_irq_reg <= (usb_irq_reg & ~clr_usb) | core_evt;
      end
   end
   // ----------------------------------------
   // enables
   // ----------------------------------------
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         in_ena_reg <= 8'h00;
         out_ena_reg <= 8'h00;
         usb_ena_reg <= 5'h00;
         autovector_enable_reg <= 1'b0;
         ext_ena_reg <= 8'h00;
      end
      else
      begin
         if (wr && bus.addr == `UIA_OFF_IN_ENA)
            in_ena_reg <= wd;
         if (wr && bus.addr == `UIA_OFF_OUT_ENA)
            out_ena_reg <= wd;
         if (wr && bus.addr == `UIA_OFF_USB_ENA)
            usb_ena_reg <= wd[4:0];
         if (wr && bus.addr == `UIA_OFF_BAV)
            autovector_enable_reg <= wd[`UIA_AV_BIT];
         if (wr && bus.addr == `UIA_OFF_EXT_ENA)
            ext_ena_reg <= wd;
      end
   end
   // ----------------------------------------
   // two-wire interrupt flag
   // ----------------------------------------
   // done rise wins over an access or a zero write in the same cycle
   always_ff @(posedge clock)
   begin
      if (sys_rst)
         ext_flag_reg <= 8'h00;
      else if (done_rise)
         ext_flag_reg[`UIA_TW_FLAG_BIT] <= 1'b1;
      else if (tw_acc)
         ext_flag_reg[`UIA_TW_FLAG_BIT] <= 1'b0;
      else if (flag_zero_wr)
         ext_flag_reg[`UIA_TW_FLAG_BIT] <= 1'b0;
   end
   // ----------------------------------------
   // two-wire control, data and stop sequencing
   // ----------------------------------------
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         tw_cs_reg <= 8'h00;
         tw_dat_reg <= 8'h00;
         tw_state_reg <= uia_pkg::UIA_TW_IDLE;
      end
      else
      begin
         tw_cs_reg[`UIA_TW_DONE_BIT] <= tw_byte_done;
         if (tw_dat_wr)
            tw_dat_reg <= wd;
         if (tw_cs_wr)
            tw_cs_reg[7:5] <= wd[7:5];
         else if (stopping && tw_stop_sent)
            tw_cs_reg[`UIA_TW_STOP_BIT] <= 1'b0;
         unique case (tw_state_reg)
            uia_pkg::UIA_TW_IDLE,
            uia_pkg::UIA_TW_XFER:
            begin
               if (tw_cs_wr && wd[`UIA_TW_STOP_BIT])
                  tw_state_reg <= uia_pkg::UIA_TW_STOP;
            end
            uia_pkg::UIA_TW_STOP:
            begin
               if (tw_stop_sent)
                  tw_state_reg <= uia_pkg::UIA_TW_IDLE;
            end
            default:
               tw_state_reg <= uia_pkg::UIA_TW_IDLE;
         endcase
      end
   end
   // ----------------------------------------
   // read data, one cycle after the strobe
   // ----------------------------------------
   always_ff @(posedge clock)
   begin
      if (sys_rst)
         rd_data_reg <= 8'h00;
      else
         rd_data_reg <= rd_ok ? rd_mux : 8'h00;
   end
endmodule : uia_device

//--- hw/uia_cpu.sv
// Purpose: processor side: register access and vector fetch
// Assumes: user side gives one command per cycle
// Notes: fetches the three vector bytes on usb_irq
`timescale 1ns/1ps
`include "uia_map.svh"
module uia_cpu
(
   input wire logic clock,
   input wire logic sys_rst,
   uia_if.cpu bus,
   input wire logic cmd_wr,
   input wire logic cmd_rd,
   input wire logic [15:0] cmd_addr,
   input wire logic [7:0] cmd_wdata,
   input wire logic [7:0] page_byte,
   output logic [7:0] cmd_rdata,
   output logic [15:0] isr_addr,
   output logic isr_valid,
   output logic tw_irq_seen
);
   logic [1:0] step_reg;
   logic [7:0] hi_reg, rdata_reg;
   logic [15:0] isr_reg;
   logic valid_reg;
   wire busy = (step_reg != 2'b00);
   // vector bytes: 0043 opcode, 0044 page, 0045 low
   wire [15:0] f_addr = `UIA_JMP_ADDR + {14'h0000, step_reg};
   wire [7:0] mem_byte = (step_reg == 2'd1) ? `UIA_JMP_OPCODE :
      (step_reg == 2'd2) ? page_byte : `UIA_RST_BYTE;
   assign bus.addr = cmd_addr;
   assign bus.wr_data = cmd_wdata;
   assign bus.wr_strobe = cmd_wr;
   assign bus.rd_strobe = cmd_rd && !cmd_wr;
   assign bus.fetch = busy;
   assign bus.fetch_addr = f_addr - 16'h0001;
   assign cmd_rdata = rdata_reg;
   assign isr_addr = isr_reg;
   assign isr_valid = valid_reg;
   assign tw_irq_seen = bus.tw_irq;
   // device overrides the low byte when autovectoring
   wire [7:0] low_byte = (step_reg == 2'd3 && bus.fetch_subst) ? bus.fetch_data : mem_byte;
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         step_reg <= 2'b00;
         hi_reg <= 8'h00;
         isr_reg <= 16'h0000;
         valid_reg <= 1'b0;
         rdata_reg <= 8'h00;
      end
      else
      begin
         rdata_reg <= bus.rd_data;
         valid_reg <= 1'b0;
         if (!busy && bus.usb_irq && !valid_reg)
            step_reg <= 2'd1;
         else if (busy)
            step_reg <= (step_reg == 2'd3) ? 2'd0 : step_reg + 2'd1;
         if (step_reg == 2'd2)
            hi_reg <= page_byte;
         if (step_reg == 2'd3)
         begin
            isr_reg <= {hi_reg, low_byte};
            valid_reg <= 1'b1;
         end
      end
   end
endmodule : uia_cpu

//--- verif/uia_monitor.sv
// Purpose: interface checker for the usb interrupt autovector block
// Assumes: autovector enabled before any usb source is enabled
// Notes: sees uia_if signals plus tw_stop_req and tw_byte_done
`timescale 1ns/1ps
module uia_monitor
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [15:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic wr_strobe,
   input wire logic rd_strobe,
   input wire logic [7:0] rd_data,
   input wire logic fetch,
   input wire logic [15:0] fetch_addr,
   input wire logic [7:0] fetch_data,
   input wire logic fetch_subst,
   input wire logic usb_irq,
   input wire logic tw_irq,
   input wire logic tw_stop_req,
   input wire logic tw_byte_done
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);
   wire tw_acc = (rd_strobe || wr_strobe) && (addr == 16'h7fa5 || addr == 16'h7fa6);
   // done edge as the device sees it; its done copy is cleared in reset
   logic done_reg;
   always_ff @(posedge clock)
   begin
      done_reg <= sys_rst ? 1'b0 : tw_byte_done;
   end
   wire done_rise = tw_byte_done && !done_reg;
   // ----
   // checks
   // ----
   a_reset_quiet: assert property ($fell(sys_rst) |-> !usb_irq && !tw_irq)
      else $error("irq active after reset");
   a_vector_order: assert property (fetch && fetch_addr == 16'h0043 |=>
      fetch && fetch_addr == 16'h0044 ##1 fetch && fetch_addr == 16'h0045)
      else $error("vector fetch out of order");
   a_fetch_cause: assert property ($rose(fetch) |->
      usb_irq || $past(usb_irq) || $past(usb_irq, 2))
      else $error("fetch without usb irq");
   a_autovector_byte_code: assert property (fetch && fetch_addr == 16'h0045 |->
      fetch_data[1:0] == 2'b00 && fetch_data <= 8'h54 && fetch_data != 8'h14)
      else $error("bad autovector byte");
   a_tw_hold: assert property (tw_irq && !wr_strobe && !rd_strobe |=> tw_irq)
      else $error("two-wire irq dropped");
   a_tw_access_clr: assert property (tw_acc && !tw_stop_req && !done_rise |=> !tw_irq)
      else $error("access left two-wire irq");
   a_tw_flag_clr: assert property (wr_strobe && addr == 16'h7fb1 && !wr_data[5] &&
      !done_rise |=> !tw_irq)
      else $error("flag write left irq");
   a_subst_addr: assert property (fetch_subst |-> fetch && fetch_addr == 16'h0045)
      else $error("substitution outside low vector byte");
   a_tw_mask: assert property (wr_strobe && addr == 16'h7fb0 && !wr_data[1] |=> !tw_irq)
      else $error("masked irq active");
   a_usb_hold: assert property (usb_irq && !wr_strobe |=> usb_irq)
      else $error("usb irq dropped");
   c_fetch: cover property (fetch && fetch_addr == 16'h0045);
   c_tw: cover property ($rose(tw_irq));
   c_usb: cover property ($rose(usb_irq));
endmodule : uia_monitor

//--- verif/usb_irq_autovector_tb.sv
// Purpose: end to end bench for the usb interrupt autovector block
// Assumes: device and processor side joined by uia_if
// Notes: prints mismatches and the verdict only
`timescale 1ns/1ps
`include "uia_map.svh"
module usb_irq_autovector_tb;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic cmd_wr = 1'b0;
   logic cmd_rd = 1'b0;
   logic [15:0] cmd_addr = 16'h0000;
   logic [7:0] cmd_wdata = 8'h00;
   logic [7:0] page_byte = 8'h04;
   logic [7:0] in_busy = 8'hff;
   logic [7:0] out_busy = 8'hff;
   logic [4:0] core_evt = 5'h00;
   logic tw_byte_done = 1'b0;
   logic tw_stop_sent = 1'b0;
   logic [7:0] cmd_rdata, b;
   logic [15:0] isr_addr, a;
   logic isr_valid, tw_irq_seen, tw_stop_req;
   int fail_count = 0;
   int n_checks = 0;
   int cnt;
   uia_if link ();
   always #20 clock = ~clock;
   uia_device u_uia_device (.clock, .sys_rst, .bus(link), .in_busy, .out_busy, .core_evt,
      .tw_byte_done, .tw_stop_sent, .tw_stop_req);
   uia_cpu u_uia_cpu (.clock, .sys_rst, .bus(link), .cmd_wr, .cmd_rd, .cmd_addr, .cmd_wdata,
      .page_byte, .cmd_rdata, .isr_addr, .isr_valid, .tw_irq_seen);
   uia_monitor u_uia_monitor (.clock, .sys_rst, .addr(link.addr), .wr_data(link.wr_data),
      .wr_strobe(link.wr_strobe), .rd_strobe(link.rd_strobe), .rd_data(link.rd_data),
      .fetch(link.fetch), .fetch_addr(link.fetch_addr), .fetch_data(link.fetch_data),
      .fetch_subst(link.fetch_subst), .usb_irq(link.usb_irq), .tw_irq(link.tw_irq),
      .tw_stop_req, .tw_byte_done);
   // ----
   // tasks
   // ----
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic results();
      if (fail_count == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : results
   task automatic wr(input logic [15:0] wa, input logic [7:0] d);
      @(posedge clock);
      cmd_wr <= 1'b1;
      cmd_addr <= wa;
      cmd_wdata <= d;
      @(posedge clock);
      cmd_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [15:0] ra, input logic [7:0] m, input logic [7:0] e);
      @(posedge clock);
      cmd_rd <= 1'b1;
      cmd_addr <= ra;
      @(posedge clock);
      cmd_rd <= 1'b0;
      @(posedge clock);
      #1;
      chk(cmd_rdata & m, e);
   endtask : rd
   // one source: enable, trigger, expect vector, clear
   task automatic av(input logic [15:0] ia, input logic [7:0] m, input logic [7:0] code);
      wr(ia + 16'h0003, m);
      @(posedge clock);
      core_evt <= (ia == 16'h7fab) ? m[4:0] : 5'h00;
      out_busy <= (ia == 16'h7faa) ? ~m : 8'hff;
      in_busy <= (ia == 16'h7fa9) ? ~m : 8'hff;
      cnt = 0;
      repeat (30)
      begin
         @(posedge clock);
         core_evt <= 5'h00;
         #1;
         cnt++;
         if (isr_valid === 1'b1) break;
      end
      chk(16'(cnt <= `UIA_DISPATCH_MAX), 16'h0001);
      chk(isr_addr, {8'h04, code});
      wr(ia, m);
      wr(ia + 16'h0003, 8'h00);
      repeat (8) @(posedge clock);
   endtask : av
   // ----
   // tests
   // ----
   initial
   begin
      repeat (10) @(posedge clock);
      sys_rst <= 1'b0;
      rd(16'h7fab, 8'hff, 8'h00);
      rd(16'h7f00, 8'hff, 8'h00);
      for (int k = 0; k < 16; k++)
      begin
         b = 8'h01 << (k % 8);
         a = (k < 8) ? 16'h7fa9 : 16'h7faa;
         @(posedge clock);
         in_busy <= (k < 8) ? ~b : 8'hff;
         out_busy <= (k < 8) ? 8'hff : ~b;
         rd(a, 8'hff, b);
         wr(a, b);
         rd(a, 8'hff, 8'h00);
      end
      wr(16'h7faf, 8'h01);
      for (int k = 0; k < 21; k++)
      begin
         a = (k < 5) ? 16'h7fab : ((k % 2) ? 16'h7fa9 : 16'h7faa);
         b = (k < 5) ? 8'h01 << k : 8'h01 << ((k - 5) / 2);
         av(a, b, (k < 5) ? 8'(4 * k) : 8'(4 * k + 4));
      end
      av(16'h7fa9, 8'h84, 8'h28);
      wr(16'h7faf, 8'h00);
      av(16'h7fab, 8'h02, 8'h00);
      wr(16'h7fb0, 8'h02);
      @(posedge clock);
      tw_byte_done <= 1'b1;
      repeat (3) @(posedge clock);
      #1;
      chk(tw_irq_seen, 1'b1);
      rd(16'h7fb1, 8'h20, 8'h20);
      rd(16'h7fa5, 8'h01, 8'h01);
      repeat (5) @(posedge clock);
      #1;
      chk(tw_irq_seen, 1'b0);
      @(posedge clock);
      tw_byte_done <= 1'b0;
      @(posedge clock);
      tw_byte_done <= 1'b1;
      repeat (3) @(posedge clock);
      #1;
      chk(tw_irq_seen, 1'b1);
      wr(16'h7fb1, 8'h00);
      @(posedge clock);
      #1;
      chk(tw_irq_seen, 1'b0);
      @(posedge clock);
      tw_byte_done <= 1'b0;
      wr(16'h7fa6, 8'h33);
      wr(16'h7fa5, 8'h40);
      @(posedge clock);
      #1;
      chk(tw_stop_req, 1'b1);
      wr(16'h7fa6, 8'h55);
      rd(16'h7fa5, 8'hff, 8'h00);
      @(posedge clock);
      tw_stop_sent <= 1'b1;
      @(posedge clock);
      tw_stop_sent <= 1'b0;
      @(posedge clock);
      #1;
      chk(tw_stop_req, 1'b0);
      rd(16'h7fa5, 8'h40, 8'h00);
      rd(16'h7fa6, 8'hff, 8'h33);
      wr(16'h7fb0, 8'h00);
      results();
   end
   initial
   begin
      repeat (20000) @(posedge clock);
      fail_count++;
      results();
   end
endmodule : usb_irq_autovector_tb
